/* File: pm_clock_gen.sv */
`timescale 1ns/1ps
`include "pulse_meter_cfg.svh"

module pm_clock_gen (
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic       run_in,
  input  wire logic       stop_in,
  input  wire logic       lf_osc_in,
  input  wire logic [1:0] filt_sel_in,
  input  wire logic [1:0] cnt_sel_in,
  output logic            filt_tick_out,
  output logic            cnt_tick_out
);

  typedef struct packed {
    logic [8:0] presc;
    logic       lf_s1;
    logic       lf_s2;
    logic       lf_prev;
    logic       lf_half;
    logic       filt_tick;
    logic       cnt_tick;
  } gen_s;

  gen_s s;
  gen_s next_s;
  logic       lf_mode;
  logic       active;
  logic       lf_rise;
  logic [8:0] fmask;
  logic [8:0] cmask;

  always_comb begin
    next_s = s;
    next_s.lf_s1 = lf_osc_in;
    next_s.lf_s2 = s.lf_s1;
    next_s.lf_prev = s.lf_s2;
    lf_rise = s.lf_s2 & ~s.lf_prev;
    lf_mode = (filt_sel_in == `PM_SEL_LF);
    active = run_in & ~(stop_in & ~lf_mode);
    case (filt_sel_in)
      2'h0: fmask = `PM_DIV16_MASK;
      2'h1: fmask = `PM_DIV32_MASK;
      default: fmask = `PM_DIV64_MASK;
    endcase
    case (cnt_sel_in)
      2'h0: cmask = `PM_DIV32_MASK;
      2'h1: cmask = `PM_DIV64_MASK;
      2'h2: cmask = `PM_DIV128_MASK;
      default: cmask = `PM_DIV512_MASK;
    endcase
    next_s.presc = active ? s.presc + `PM_PRESC_ONE : '0;
    if (lf_mode) begin
      next_s.filt_tick = active & lf_rise;
      next_s.cnt_tick = active & lf_rise & s.lf_half;
      if (active & lf_rise) begin
        next_s.lf_half = ~s.lf_half;
      end
    end else begin
      next_s.filt_tick = active & ((s.presc & fmask) == fmask);
      next_s.cnt_tick = active & ((s.presc & cmask) == cmask);
    end
    if (!active) begin
      next_s.lf_half = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign filt_tick_out = s.filt_tick;
  assign cnt_tick_out  = s.cnt_tick;

endmodule

/* File: pm_noise_filter.sv */
`timescale 1ns/1ps

module pm_noise_filter #(
  parameter int TAPS = 3
) (
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic pin_in,
  input  wire logic run_in,
  input  wire logic invert_in,
  input  wire logic tick_in,
  output logic      sync_out,
  output logic      level_out
);

  generate
    if (TAPS < 2) begin : g_bad_taps
      $error("pm_noise_filter needs at least two taps");
    end
  endgenerate

  typedef struct packed {
    logic            s1;
    logic            s2;
    logic [TAPS-1:0] hist;
    logic            level;
  } filt_s;

  filt_s s;
  filt_s next_s;
  logic  samp;

  // ----------------------------------------
  // Level changes only after TAPS equal samples, or clears while run_in is low
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.s1 = pin_in;
    next_s.s2 = s.s1;
    samp = s.s2 ^ invert_in;
    if (!run_in) begin
      next_s.hist = '0;
      next_s.level = 1'b0;
    end else if (tick_in) begin
      next_s.hist = {s.hist[TAPS-2:0], samp};
      if (&next_s.hist) begin
        next_s.level = 1'b1;
      end else if (~|next_s.hist) begin
        next_s.level = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out  = s.s2;
  assign level_out = s.level;

endmodule

/* File: pm_pulse_src.sv */
`timescale 1ns/1ps

// Pulse source on the shared pin; idles low, toggles every half_in cycles
module pm_pulse_src (
  input wire logic        core_clk_in,
  input wire logic        run_in,
  input wire logic [15:0] half_in,
  output logic            pulse_out
);
  logic [15:0] cnt;

  initial pulse_out = 1'b0;

  always @(posedge core_clk_in) begin
    if (!run_in) begin
      cnt       <= 16'h0;
      pulse_out <= 1'b0;
    end else if (cnt == half_in - 16'h1) begin
      cnt       <= 16'h0;
      pulse_out <= ~pulse_out;
    end else begin
      cnt <= cnt + 16'h1;
    end
  end
endmodule

/* File: pulse_meter_cfg.svh */
`ifndef PULSE_METER_CFG_SVH
`define PULSE_METER_CFG_SVH

// ----------------------------------------
// Register word indices (byte address = 4 * index)
// ----------------------------------------
`define PM_CTRL_IDX      6'h0d
`define PM_STAT_IDX      6'h0e
`define PM_DATA_IDX      6'h0f
`define PM_ADDR_LANE     2'h0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PM_CTRL_RST      8'h0f

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define PM_ST_IRQ_EN     5

// ----------------------------------------
// Prescaler masks (divide ratio - 1)
// ----------------------------------------
`define PM_DIV16_MASK    9'h00f
`define PM_DIV32_MASK    9'h01f
`define PM_DIV64_MASK    9'h03f
`define PM_DIV128_MASK   9'h07f
`define PM_DIV512_MASK   9'h1ff
`define PM_PRESC_ONE     9'h001
`define PM_SEL_LF        2'h3

// ----------------------------------------
// Counter and queue
// ----------------------------------------
`define PM_CNT_MAX       8'hff
`define PM_CNT_ONE       8'h01
`define PM_QUEUE_DEPTH   6
`define PM_IRQ_FILL      4

`endif

/* File: pulse_meter_pkg.sv */
package pulse_meter_pkg;

  // Control register image, bit 7 first
  typedef struct packed {
    logic       enable;
    logic       edge_mode;
    logic       irq_src;
    logic       invert;
    logic [1:0] cnt_sel;
    logic [1:0] filt_sel;
  } ctrl_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef enum logic {
    ph_idle,
    ph_ack
  } apb_phase_e;

endpackage

/* File: queued_pulse_width_meter.sv */
// Behaviour
// - Stop mode runs only on low-frequency clock
// - Control byte layout, resets to 0x0f
// - Disabled: clocks stop, queue and flags reset
// - Enabled: shared pin becomes pulse input
// - Edge mode: both phases or full period
// - Irq flag on rising edge or four stored
// - Invert input when input_invert set
// - Level bit updates after queue read, clears when disabled
// - Status bit 6 shows filter output
// - irq_enable gates the interrupt request
// - Overflow flag set, cleared by disabling
// - Status read then data access clears flag
// - Overflow also requests interrupt, gated by irq_enable
// - Overrun set on store into full queue
// - Full flag clears on read or disable
// - Empty flag resets set, clears on store
// - Data register returns oldest queued width
// - Counter start, store, restart, halt, resume
// - Six-entry queue, last slot overwritten
// - Filter and counter clock selection
`timescale 1ns/1ps
`include "pulse_meter_cfg.svh"

module queued_pulse_width_meter #(
  parameter int DEPTH = `PM_QUEUE_DEPTH,
  parameter int TAPS  = 3
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_in,
  input  wire pulse_meter_pkg::apb_req_s apb_in,
  output pulse_meter_pkg::apb_rsp_s      apb_out,
  input  wire logic                     stop_mode_in,
  input  wire logic                     low_freq_osc_in,
  input  wire logic                     port_a_line7_in,
  input  wire logic                     gpio_out_in,
  input  wire logic                     gpio_oe_in,
  output logic                          port_a_line7_out,
  output logic                          port_a_line7_oe_out,
  output logic                          port_a_line7_read_out,
  output logic                          irq_out
);

  localparam int QW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < `PM_IRQ_FILL) begin : g_bad_depth
      $error("queue depth must hold the fill threshold");
    end
  endgenerate

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    pulse_meter_pkg::apb_phase_e phase;
    logic                        pready;
    logic                        pslverr;
    logic [7:0]                  prdata;
    pulse_meter_pkg::ctrl_s      ctrl;
    logic                        irq_en;
    logic                        ovf;
    logic                        irqf;
    logic                        queue_overrun_flag;
    logic                        armed;
    logic                        pl;
    logic [7:0]                  count;
    logic                        running;
    logic                        halted;
    logic                        prev_lvl;
    logic [QW-1:0]               qcnt;
    logic [DEPTH-1:0][8:0]       queue;
    logic                        irq;
    logic                        pin_out;
    logic                        pin_oe;
    logic                        pin_rd;
  } meter_s;

  meter_s s;
  meter_s next_s;

  logic          filt_tick;
  logic          cnt_tick;
  logic          sync_lvl;
  logic          lvl;
  logic          access;
  logic          complete;
  logic          sel_ctrl;
  logic          sel_stat;
  logic          sel_data;
  logic          rise;
  logic          fall;
  logic          meas_edge;
  logic          store;
  logic          fill_hit;
  logic [QW-1:0] qafter;
  logic [7:0]    status;

  // ----------------------------------------
  // Clock sources and noise filter
  // ----------------------------------------
  pm_clock_gen u_clock_gen (
    .core_clk_in   (core_clk_in),
    .reset_in      (reset_in),
    .run_in        (s.ctrl.enable),
    .stop_in       (stop_mode_in),
    .lf_osc_in     (low_freq_osc_in),
    .filt_sel_in   (s.ctrl.filt_sel),
    .cnt_sel_in    (s.ctrl.cnt_sel),
    .filt_tick_out (filt_tick),
    .cnt_tick_out  (cnt_tick)
  );

  pm_noise_filter #(
    .TAPS (TAPS)
  ) u_noise_filter (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .pin_in      (port_a_line7_in),
    .run_in      (s.ctrl.enable),
    .invert_in   (s.ctrl.invert),
    .tick_in     (filt_tick),
    .sync_out    (sync_lvl),
    .level_out   (lvl)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    status = {s.pl, lvl, s.irq_en, s.ovf, s.irqf, s.queue_overrun_flag,
              s.qcnt == QW'(DEPTH), s.qcnt == '0};

    // Shared pin: port drives it only while the meter is off
    next_s.pin_oe = ~s.ctrl.enable & gpio_oe_in;
    next_s.pin_out = gpio_out_in;
    next_s.pin_rd = sync_lvl;

    // Register bus: setup, one wait cycle, then ready
    access = apb_in.psel & apb_in.penable;
    complete = access & (s.phase == pulse_meter_pkg::ph_ack);
    sel_ctrl = (apb_in.paddr[7:2] == `PM_CTRL_IDX) & (apb_in.paddr[1:0] == `PM_ADDR_LANE);
    sel_stat = (apb_in.paddr[7:2] == `PM_STAT_IDX) & (apb_in.paddr[1:0] == `PM_ADDR_LANE);
    sel_data = (apb_in.paddr[7:2] == `PM_DATA_IDX) & (apb_in.paddr[1:0] == `PM_ADDR_LANE);
    case (s.phase)
      pulse_meter_pkg::ph_idle: begin
        if (access) begin
          next_s.phase = pulse_meter_pkg::ph_ack;
          next_s.pready = 1'b1;
          next_s.pslverr = ~(sel_ctrl | sel_stat | sel_data);
          if (apb_in.pwrite || !(sel_ctrl | sel_stat | sel_data)) begin
            next_s.prdata = '0;
          end else if (sel_ctrl) begin
            next_s.prdata = s.ctrl;
          end else if (sel_stat) begin
            next_s.prdata = status;
          end else begin
            next_s.prdata = s.queue[0][7:0];
          end
        end
      end
      pulse_meter_pkg::ph_ack: begin
        next_s.phase = pulse_meter_pkg::ph_idle;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
      end
      default: begin
        next_s.phase = pulse_meter_pkg::ph_idle;
        next_s.pready = 1'b0;
      end
    endcase

    if (complete && apb_in.pwrite && sel_ctrl) begin
      next_s.ctrl = pulse_meter_pkg::ctrl_s'(apb_in.pwdata[7:0]);
    end
    if (complete && apb_in.pwrite && sel_stat) begin
      next_s.irq_en = apb_in.pwdata[`PM_ST_IRQ_EN];
    end

    // Edge detection on the filtered level
    rise = lvl & ~s.prev_lvl;
    fall = ~lvl & s.prev_lvl;
    next_s.prev_lvl = lvl;
    meas_edge = s.ctrl.edge_mode ? (rise | fall) : rise;

    // Width counter
    store = 1'b0;
    if (meas_edge) begin
      store = s.running & ~s.halted;
      next_s.count = '0;
      next_s.running = 1'b1;
      next_s.halted = 1'b0;
    end else if (fall && s.halted) begin
      next_s.count = '0;
      next_s.halted = 1'b0;
    end else if (cnt_tick && s.running && !s.halted) begin
      if (s.count == `PM_CNT_MAX) begin
        next_s.halted = 1'b1;
        next_s.ovf = 1'b1;
      end else begin
        next_s.count = s.count + `PM_CNT_ONE;
      end
    end

    // Queue: pop on data read, then push a finished width
    qafter = s.qcnt;
    if (complete && !apb_in.pwrite && sel_data && s.qcnt != '0) begin
      next_s.pl = s.queue[0][8];
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_s.queue[i] = s.queue[i+1];
      end
      qafter = s.qcnt - QW'(1);
    end
    next_s.qcnt = qafter;
    fill_hit = 1'b0;
    if (store) begin
      if (qafter == QW'(DEPTH)) begin
        next_s.queue[DEPTH-1] = {s.prev_lvl, s.count};
        next_s.queue_overrun_flag = 1'b1;
      end else begin
        next_s.queue[qafter] = {s.prev_lvl, s.count};
        next_s.qcnt = qafter + QW'(1);
        fill_hit = (qafter + QW'(1)) == QW'(`PM_IRQ_FILL);
      end
    end

    // Interrupt flag: clear by status read then data access, set wins
    if (complete && sel_data && s.armed) begin
      next_s.irqf = 1'b0;
      next_s.armed = 1'b0;
    end
    if (complete && !apb_in.pwrite && sel_stat && s.irqf) begin
      next_s.armed = 1'b1;
    end
    if (s.ctrl.irq_src ? rise : fill_hit) begin
      next_s.irqf = 1'b1;
    end
    next_s.irq = s.irq_en & (s.irqf | s.ovf);

    // Disabled: counter stopped, queue emptied, flags at reset
    if (!s.ctrl.enable) begin
      next_s.ovf = 1'b0;
      next_s.irqf = 1'b0;
      next_s.armed = 1'b0;
      next_s.queue_overrun_flag = 1'b0;
      next_s.pl = 1'b0;
      next_s.qcnt = '0;
      next_s.count = '0;
      next_s.running = 1'b0;
      next_s.halted = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      s <= '0;
      s.ctrl <= pulse_meter_pkg::ctrl_s'(`PM_CTRL_RST);
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign apb_out.pready        = s.pready;
  assign apb_out.pslverr       = s.pslverr;
  assign apb_out.prdata        = {24'h000000, s.prdata};
  assign port_a_line7_out      = s.pin_out;
  assign port_a_line7_oe_out   = s.pin_oe;
  assign port_a_line7_read_out = s.pin_rd;
  assign irq_out               = s.irq;

endmodule

/* File: queued_pulse_width_meter_sva.sv */
`timescale 1ns/1ps

module pm_checker (
  input wire logic                      core_clk_in,
  input wire logic                      reset_in,
  input wire pulse_meter_pkg::apb_req_s apb_in,
  input wire pulse_meter_pkg::apb_rsp_s apb_out,
  input wire logic                      gpio_out_in,
  input wire logic                      gpio_oe_in,
  input wire logic                      port_a_line7_in,
  input wire logic                      port_a_line7_out,
  input wire logic                      port_a_line7_oe_out,
  input wire logic                      port_a_line7_read_out,
  input wire logic                      irq_out
);
  // ----
  // Shadow of software-visible state
  // ----
  logic [7:0] ctrl;
  logic       ie;
  logic [1:0] en_age;
  logic [2:0] rst_age;
  wire        wr_ok  = apb_out.pready && apb_in.pwrite && !apb_out.pslverr;
  wire        mapped = apb_in.paddr inside {8'h34, 8'h38, 8'h3c};
  wire        rd_ok  = apb_out.pready && !apb_in.pwrite;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl    <= 8'h0f;
      ie      <= 1'b0;
      en_age  <= 2'h0;
      rst_age <= 3'h0;
    end else begin
      if (wr_ok && apb_in.paddr == 8'h34) begin
        ctrl   <= apb_in.pwdata[7:0];
        en_age <= 2'h0;
      end else if (en_age != 2'h3) begin
        en_age <= en_age + 2'h1;
      end
      if (wr_ok && apb_in.paddr == 8'h38) begin
        ie <= apb_in.pwdata[5];
      end
      if (rst_age != 3'h4) begin
        rst_age <= rst_age + 3'h1;
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_access;
    apb_in.psel && apb_in.penable && !apb_out.pready;
  endsequence

  a_ready_wait: assert property (s_access |=> apb_out.pready)
    else $error("pready missing after access phase");
  a_ready_pulse: assert property (apb_out.pready |=> !apb_out.pready)
    else $error("pready longer than one cycle");
  a_slverr_map: assert property (s_access |=> apb_out.pslverr == !mapped)
    else $error("pslverr does not match address map");
  a_rdata_upper: assert property (rd_ok |-> apb_out.prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_ctrl_read: assert property (rd_ok && apb_in.paddr == 8'h34 |-> apb_out.prdata[7:0] == ctrl)
    else $error("control readback wrong");
  a_pin_taken: assert property (en_age == 2'h3 && ctrl[7] |-> !port_a_line7_oe_out)
    else $error("pin driven while meter enabled");
  a_pin_gpio: assert property (en_age == 2'h3 && !ctrl[7] |-> port_a_line7_oe_out == $past(gpio_oe_in))
    else $error("pin enable not from port logic");
  a_out_copy: assert property (!$past(reset_in) |-> port_a_line7_out == $past(gpio_out_in))
    else $error("pin output not port latch");
  a_read_sync: assert property (rst_age == 3'h4 |-> port_a_line7_read_out == $past(port_a_line7_in, 3))
    else $error("pin read path delay wrong");
  a_irq_gated: assert property (irq_out |-> ie || $past(ie))
    else $error("interrupt while disabled");
endmodule

/* File: queued_pulse_width_meter_tb.sv */
`timescale 1ns/1ps
`define CHK(n, x, g) begin total_checks++; if ((g) !== (x)) begin fails++; \
  $display("unexpected %s exp %h got %h", n, x, g); end end

module queued_pulse_width_meter_tb;
  logic                      clk  = 1'b0;
  logic                      rst  = 1'b1;
  logic                      stop = 1'b0;
  logic                      lfo  = 1'b0;
  logic                      gout = 1'b0;
  logic                      run  = 1'b0;
  logic [15:0]               half = 16'd320;
  logic                      pin, pout, poe, prd, irq, e;
  logic [31:0]               r;
  pulse_meter_pkg::apb_req_s req = '0;
  pulse_meter_pkg::apb_rsp_s rsp;
  int                        fails = 0;
  int                        total_checks = 0;

  always #25 clk = ~clk;
  always #2000 lfo = ~lfo;
  always @(posedge clk) gout <= ~gout;

  pm_pulse_src src (.core_clk_in(clk), .run_in(run), .half_in(half), .pulse_out(pin));

  queued_pulse_width_meter dut (
    .core_clk_in(clk), .reset_in(rst), .apb_in(req), .apb_out(rsp),
    .stop_mode_in(stop), .low_freq_osc_in(lfo), .port_a_line7_in(pin),
    .gpio_out_in(gout), .gpio_oe_in(1'b1), .port_a_line7_out(pout),
    .port_a_line7_oe_out(poe), .port_a_line7_read_out(prd), .irq_out(irq));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n >= 20) begin
      fails++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] x, input string nm);
    rd(a);
    `CHK(nm, x, r[7:0])
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    tick(60000);
    fails++;
    finish_test();
  end

  initial begin
    tick(12);
    rst <= 1'b0;
    rdc(8'h34, 8'h0f, "ctrl reset");
    rdc(8'h38, 8'h01, "status reset");
    rdc(8'h3c, 8'h00, "data reset");
    rd(8'h40);
    `CHK("slverr", 1'b1, e)
    wr(8'h38, 8'hff);
    rdc(8'h38, 8'h21, "status write");
    `CHK("pin oe", 1'b1, poe)
    $display("test registers done");
    wr(8'h34, 8'hc0);
    tick(3);
    `CHK("pin oe on", 1'b0, poe)
    run <= 1'b1;
    tick(5000);
    run <= 1'b0;
    // Let the trailing edge from stopping the source land before draining
    tick(200);
    rd(8'h38);
    `CHK("status fill", 6'h2e, r[5:0])
    `CHK("irq", 1'b1, irq)
    for (int i = 0; i < 6; i++) begin
      rd(8'h3c);
      if (i < 5) `CHK("width", 1'b1, r[7:0] >= 8'd9 && r[7:0] <= 8'd11)
      rd(8'h38);
      if (i < 5) `CHK("level", !i[0], r[7])
      if (i == 0) `CHK("flag clear", 2'b00, {r[3], r[1]})
    end
    `CHK("empty", 1'b1, r[0])
    tick(9000);
    rd(8'h38);
    `CHK("overflow", 1'b1, r[4])
    `CHK("irq ovf", 1'b1, irq)
    wr(8'h34, 8'h40);
    rdc(8'h38, 8'h21, "status off");
    tick(3);
    `CHK("irq off", 1'b0, irq)
    $display("test queue done");
    wr(8'h34, 8'h90);
    tick(200);
    rd(8'h38);
    `CHK("filtered", 1'b1, r[6])
    wr(8'h34, 8'h00);
    wr(8'h34, 8'ha0);
    run <= 1'b1;
    tick(1400);
    run <= 1'b0;
    rd(8'h38);
    `CHK("edge flag", 2'b10, {r[3], r[0]})
    rd(8'h3c);
    `CHK("period", 1'b1, r[7:0] >= 8'd19 && r[7:0] <= 8'd21)
    wr(8'h34, 8'h00);
    stop <= 1'b1;
    wr(8'h34, 8'hc0);
    run <= 1'b1;
    tick(2000);
    run <= 1'b0;
    rdc(8'h38, 8'h21, "stop main");
    wr(8'h34, 8'h00);
    half <= 16'd640;
    wr(8'h34, 8'hc3);
    run <= 1'b1;
    tick(4000);
    run <= 1'b0;
    rd(8'h38);
    `CHK("stop low freq", 1'b0, r[0])
    stop <= 1'b0;
    $display("test modes done");
    finish_test();
  end
endmodule

bind queued_pulse_width_meter pm_checker u_chk (
  .core_clk_in, .reset_in, .apb_in, .apb_out, .gpio_out_in, .gpio_oe_in,
  .port_a_line7_in, .port_a_line7_out, .port_a_line7_oe_out,
  .port_a_line7_read_out, .irq_out);
